/* File: verilog/prio_ctl_regs.svh */
`ifndef PRIO_CTL_REGS_SVH
`define PRIO_CTL_REGS_SVH
// clock period and main time tick; 2^28 ticks of 10 ms span 745.65 hours
`define CLK_PERIOD_NS    20
`define MAIN_TICK_NS     10000000
`define TIME_SPAN_CHOURS 74565
// memory-resident counter slots
`define CNT_TIME_LO      2'h0
`define CNT_TIME_HI      2'h1
`define CNT_UPLINK       2'h2
`define CNT_SLOTS        3
// reset value of a counter word: zero data, odd parity bit set
`define CNT_RESET_WORD   16'h8000
// interrupt program vectors: base plus four words per priority level
`define VEC_BASE         12'h800
`define RESTART_ADDR     12'h000
// timer interrupt rates as masks on the tick count (values arbitrary)
`define T6_MASK          8'h00
`define T5_MASK          8'h01
`define T3_MASK          8'h03
`define T4_MASK          8'h07
// uplink word length in serial bits
`define UPLINK_BITS      4'hf
// pending-condition bit positions
`define PB_KEY2          5
`define PB_MARK          6
`define PB_UPLINK        7
`define PB_DOWN          8
`define PB_HAND          9
`endif

/* File: verilog/prio_ctl_pkg.sv */
package prio_ctl_pkg;
   // sequencing of boundary work
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_DECIDE = 2'b01,
      ST_CNT_RD = 2'b10,
      ST_CNT_WR = 2'b11
   } state_t;
   // kind of priority request issued to the sequencer
   typedef enum logic [1:0] {
      RK_NONE = 2'b00,
      RK_CNT  = 2'b01,
      RK_INT  = 2'b10,
      RK_RES  = 2'b11
   } req_kind_t;
endpackage : prio_ctl_pkg

/* File: verilog/odd_parity.sv */
`timescale 1ns/100ps
`default_nettype none
// odd parity generate for writes and check for reads
module odd_parity #(
   parameter int W = 15
) (
   // data going to memory
   input  wire logic [W-1:0] wr_data,
   output wire logic         wr_par,
   // full word coming from memory
   input  wire logic [W:0]   rd_word,
   output wire logic         rd_ok
);
   // parity bit makes the ones count odd
   assign wr_par = ~(^wr_data);
   // a good word holds an odd number of ones
   assign rd_ok  = ^rd_word;
endmodule : odd_parity
`default_nettype wire

/* File: verilog/ones_comp_adder.sv */
`timescale 1ns/100ps
`default_nettype none
// ones-complement adder: sign plus M magnitude bits, end-around carry
module ones_comp_adder #(
   parameter int M = 14
) (
   // operands
   input  wire logic [M:0] a,
   input  wire logic [M:0] b,
   // result and overflow or underflow flag
   output wire logic [M:0] sum,
   output wire logic       ovf
);
   logic [M+1:0] raw;   // sum with carry out
   assign raw = {1'b0, a} + {1'b0, b};
   // end-around carry folds back into the low bit
   assign sum = raw[M:0] + {{M{1'b0}}, raw[M+1]};
   // like signs giving an unlike sign is overflow
   assign ovf = (a[M] == b[M]) && (sum[M] != a[M]);
endmodule : ones_comp_adder
`default_nettype wire

/* File: verilog/priority_interrupt_counter_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "prio_ctl_regs.svh"
module priority_interrupt_counter_control #(
   parameter int TICK_CYCLES = `MAIN_TICK_NS / `CLK_PERIOD_NS,
   parameter int AW          = 12
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // event sources
   input  wire logic                    key_press_first,
   input  wire logic                    key_press_second,
   input  wire logic                    mark_discrete,
   input  wire logic                    uplink_pulse,
   input  wire logic                    uplink_bit,
   input  wire logic                    hand_out_of_detent,
   input  wire logic                    downlink_end,
   // sequencer and central processor
   input  wire logic                    instr_done,
   input  wire logic                    resume_req,
   input  wire logic [15:0]             acc_in,
   // priority requests and program state
   output logic                         hold_r,
   output prio_ctl_pkg::req_kind_t      req_kind_r,
   output logic [AW-1:0]                req_addr_r,
   output logic [AW-1:0]                pc_r,
   output logic [15:0]                  acc_out_r,
   output logic                         acc_load_r,
   output logic                         in_isr_r,
   output logic                         parity_err_r
);
   import prio_ctl_pkg::*;
   // all checks run on the rising clock and rest during reset
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // lowest set level wins
   function automatic logic [3:0] first_level(input logic [8:0] v);
      logic [3:0] r;
      r = 4'hf;
      for (int i = 8; i >= 0; i--) if (v[i]) r = i[3:0];
      return r;
   endfunction : first_level
   // pending bits served by one level; mark rides with second keyboard
   function automatic logic [9:0] level_mask(input logic [3:0] l);
      logic [9:0] m;
      m = 10'h000;
      if (l < 4'd5) m[l] = 1'b1;
      else if (l == 4'd5) m = 10'h060;
      else m[l + 4'd1] = 1'b1;
      return m;
   endfunction : level_mask
   // next sequential address
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
      return a + {{(AW-1){1'b0}}, 1'b1};
   endfunction : next_addr
   state_t          state_r;       // boundary sequencer state
   logic [19:0]     div_r;         // main tick divider
   logic [7:0]      tick_cnt_r;    // counts main ticks for timer rates
   logic [9:0]      pend_r;        // held interrupt conditions
   logic            mark_prev_r;   // for mark edge
   logic            hand_prev_r;   // for detent edge
   logic            time_pend_r;   // time counter increment waiting
   logic            carry_pend_r;  // high time word increment waiting
   logic            up_pend_r;     // uplink shift step waiting
   logic            up_bit_r;      // bit for the waiting shift step
   logic [3:0]      up_cnt_r;      // uplink bits assembled so far
   logic            resume_r;      // boundary came from closing instruction
   logic [1:0]      cidx_r;        // counter being updated
   logic [15:0]     rd_word_r;     // counter word as read
   logic [AW-1:0]   saved_pc_r;    // interrupted program counter
   logic [15:0]     saved_acc_r;   // interrupted intermediate result
   logic [15:0]     cnt_mem_r [`CNT_SLOTS];  // memory-resident counters

   // decode wires
   logic            tick, boundary, lvl_any, cnt_any, enter, up_word;
   logic            inc_ovf, new_par, rd_ok, carry_set;
   logic [9:0]      set_v, clr_v;
   logic [8:0]      lvl;
   logic [3:0]      top_lvl;
   logic [AW-1:0]   vec;
   logic [1:0]      pick;
   logic [14:0]     inc_sum, new_data;
   logic [15:0]     wr_word;

   // main tick every 10 ms
   assign tick     = (div_r == 20'(TICK_CYCLES - 1));
   assign boundary = instr_done | resume_req;
   // word complete on the last shift step
   assign up_word  = (state_r == ST_CNT_WR) && (cidx_r == `CNT_UPLINK)
                     && (up_cnt_r == `UPLINK_BITS - 4'h1);
   // interrupt conditions, set this cycle
   assign set_v[0] = tick && ((tick_cnt_r & `T6_MASK) == 8'h00);
   assign set_v[1] = tick && ((tick_cnt_r & `T5_MASK) == 8'h00);
   assign set_v[2] = tick && ((tick_cnt_r & `T3_MASK) == 8'h00);
   assign set_v[3] = tick && ((tick_cnt_r & `T4_MASK) == 8'h00);
   assign set_v[4] = key_press_first;
   assign set_v[`PB_KEY2]   = key_press_second;
   assign set_v[`PB_MARK]   = mark_discrete & ~mark_prev_r;
   assign set_v[`PB_UPLINK] = up_word;
   assign set_v[`PB_DOWN]   = downlink_end;
   assign set_v[`PB_HAND]   = hand_out_of_detent & ~hand_prev_r;
   // nine priority levels over ten conditions
   assign lvl = {pend_r[9:7], pend_r[`PB_KEY2] | pend_r[`PB_MARK], pend_r[4:0]};
   assign lvl_any = |lvl;
   assign top_lvl = first_level(lvl);
   assign vec     = `VEC_BASE | {{(AW-6){1'b0}}, top_lvl, 2'b00};
   // an interrupt program is entered from the decide state
   assign enter   = (state_r == ST_DECIDE) && !cnt_any && lvl_any && (resume_r || !in_isr_r);
   assign clr_v   = enter ? level_mask(top_lvl) : 10'h000;
   // counters: carry first, then time, then uplink
   assign cnt_any = carry_pend_r | time_pend_r | up_pend_r;
   assign pick    = carry_pend_r ? `CNT_TIME_HI : time_pend_r ? `CNT_TIME_LO : `CNT_UPLINK;
   // modify step on the counter word
   ones_comp_adder #(.M(14)) u_inc (
      .a   (rd_word_r[14:0]),
      .b   (15'h0001),
      .sum (inc_sum),
      .ovf (inc_ovf)
   );
   // only the write step of the low word may queue a carry, once
   assign carry_set = (state_r == ST_CNT_WR) && (cidx_r == `CNT_TIME_LO) && inc_ovf;
   // time words wrap to zero on overflow; uplink shifts one bit in
   assign new_data = (cidx_r == `CNT_UPLINK) ? {rd_word_r[13:0], up_bit_r} :
                     inc_ovf ? 15'h0000 : inc_sum;
   odd_parity #(.W(15)) u_par (
      .wr_data (new_data),
      .wr_par  (new_par),
      .rd_word (rd_word_r),
      .rd_ok   (rd_ok)
   );
   assign wr_word = {new_par, new_data};

   // tick divider and timer rate count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_r      <= 20'h00000;
         tick_cnt_r <= 8'h00;
      end else begin
         div_r      <= tick ? 20'h00000 : div_r + 20'h00001;
         tick_cnt_r <= tick ? tick_cnt_r + 8'h01 : tick_cnt_r;
      end
   end

   // held interrupt conditions; a new set beats the entry clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend_r      <= 10'h000;
         mark_prev_r <= 1'b0;
         hand_prev_r <= 1'b0;
      end else begin
         pend_r      <= (pend_r & ~clr_v) | set_v;
         mark_prev_r <= mark_discrete;
         hand_prev_r <= hand_out_of_detent;
      end
   end

   // incremental pulses wait here until a boundary serves them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         time_pend_r  <= 1'b0;
         carry_pend_r <= 1'b0;
         up_pend_r    <= 1'b0;
         up_bit_r     <= 1'b0;
      end else begin
         time_pend_r  <= tick | (time_pend_r &
                         !(state_r == ST_DECIDE && pick == `CNT_TIME_LO));
         carry_pend_r <= carry_set | (carry_pend_r &
                         !(state_r == ST_DECIDE && pick == `CNT_TIME_HI));
         up_pend_r    <= uplink_pulse | (up_pend_r &
                         !(state_r == ST_DECIDE && pick == `CNT_UPLINK));
         up_bit_r     <= uplink_pulse ? uplink_bit : up_bit_r;
      end
   end

   // counter memory write back
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `CNT_SLOTS; i++) cnt_mem_r[i] <= `CNT_RESET_WORD;
      end else if (state_r == ST_CNT_WR) begin
         cnt_mem_r[cidx_r] <= wr_word;
      end
   end

   // uplink bit count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         up_cnt_r <= 4'h0;
      end else if (state_r == ST_CNT_WR && cidx_r == `CNT_UPLINK) begin
         up_cnt_r <= up_word ? 4'h0 : up_cnt_r + 4'h1;
      end
   end

   // boundary sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r      <= ST_IDLE;
         hold_r       <= 1'b0;
         resume_r     <= 1'b0;
         cidx_r       <= `CNT_TIME_LO;
         rd_word_r    <= `CNT_RESET_WORD;
         req_kind_r   <= RK_NONE;
         req_addr_r   <= `RESTART_ADDR;
         pc_r         <= `RESTART_ADDR;
         saved_pc_r   <= `RESTART_ADDR;
         saved_acc_r  <= 16'h0000;
         acc_out_r    <= 16'h0000;
         acc_load_r   <= 1'b0;
         in_isr_r     <= 1'b0;
         parity_err_r <= 1'b0;
      end else begin
         req_kind_r   <= RK_NONE;
         acc_load_r   <= 1'b0;
         parity_err_r <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin // wait for the end of an instruction
               if (boundary) begin
                  hold_r   <= 1'b1;
                  resume_r <= resume_req;
                  state_r  <= ST_DECIDE;
               end
            end
            ST_DECIDE: begin // counters first, then program flow
               if (cnt_any) begin
                  cidx_r     <= pick;
                  req_kind_r <= RK_CNT;
                  req_addr_r <= {{(AW-2){1'b0}}, pick};
                  state_r    <= ST_CNT_RD;
               end else begin
                  hold_r  <= 1'b0;
                  state_r <= ST_IDLE;
                  if (enter) begin
                     if (!resume_r) begin // chained entry keeps the first saved state
                        saved_pc_r  <= next_addr(pc_r);
                        saved_acc_r <= acc_in;
                     end
                     pc_r       <= vec;
                     in_isr_r   <= 1'b1;
                     req_kind_r <= RK_INT;
                     req_addr_r <= vec;
                  end else if (resume_r) begin
                     pc_r       <= saved_pc_r;
                     acc_out_r  <= saved_acc_r;
                     acc_load_r <= 1'b1;
                     in_isr_r   <= 1'b0;
                     req_kind_r <= RK_RES;
                     req_addr_r <= saved_pc_r;
                  end else begin
                     pc_r <= next_addr(pc_r);
                  end
               end
            end
            ST_CNT_RD: begin // read the addressed counter
               rd_word_r <= cnt_mem_r[cidx_r];
               state_r   <= ST_CNT_WR;
            end
            ST_CNT_WR: begin // modify and write back, flag a bad read
               parity_err_r <= !rd_ok;
               state_r      <= ST_DECIDE;
            end
         endcase
      end
   end

   // checks
   property p_key_held;
      @(posedge clk) disable iff (!rstn) key_press_first |=> pend_r[4];
   endproperty
   a_key_held: assert property (p_key_held) else $error("key press lost");
   property p_mark_level;
      @(posedge clk) disable iff (!rstn) $rose(mark_discrete) |=> pend_r[`PB_MARK] && lvl[5];
   endproperty
   a_mark_level: assert property (p_mark_level) else $error("mark level wrong");
   property p_hand;
      $rose(hand_out_of_detent) |=> pend_r[`PB_HAND];
   endproperty
   a_hand: assert property (p_hand) else $error("detent not seen");
   property p_down;
      @(posedge clk) disable iff (!rstn) downlink_end |=> pend_r[`PB_DOWN];
   endproperty
   a_down: assert property (p_down) else $error("downlink done lost");
   property p_enter;
      enter && !resume_r |=> pc_r == $past(vec) && in_isr_r
         && saved_pc_r == $past(pc_r) + 12'h001;
   endproperty
   a_enter: assert property (p_enter) else $error("bad entry");
   property p_resume;
      req_kind_r == RK_RES |-> pc_r == saved_pc_r && !in_isr_r && acc_load_r;
   endproperty
   a_resume: assert property (p_resume) else $error("bad resume");
   property p_cnt_held;
      @(posedge clk) disable iff (!rstn) state_r == ST_CNT_RD |-> hold_r ##1 hold_r;
   endproperty
   a_cnt_held: assert property (p_cnt_held) else $error("counter not held");
   property p_cnt_first;
      state_r == ST_DECIDE && cnt_any |=> state_r == ST_CNT_RD ##2 state_r == ST_DECIDE;
   endproperty
   a_cnt_first: assert property (p_cnt_first) else $error("counter not first");
   property p_next;
      state_r == ST_DECIDE && !cnt_any && !enter && !resume_r |=> pc_r == $past(pc_r) + 12'h001;
   endproperty
   a_next: assert property (p_next) else $error("pc not advanced");
   property p_parity;
      @(posedge clk) disable iff (!rstn) state_r == ST_CNT_WR |-> ^wr_word;
   endproperty
   a_parity: assert property (p_parity) else $error("even parity written");
   property p_tick;
      @(posedge clk) disable iff (!rstn) tick |=> time_pend_r;
   endproperty
   a_tick: assert property (p_tick) else $error("tick lost");
   c_enter: cover property (@(posedge clk) req_kind_r == RK_INT);
   c_resume: cover property (@(posedge clk) req_kind_r == RK_RES);
   c_carry: cover property (@(posedge clk) carry_set);
   c_upword: cover property (@(posedge clk) up_word);
endmodule : priority_interrupt_counter_control
`default_nettype wire

/* File: verif/seq_model.sv */
`timescale 1ns/100ps
`default_nettype none
// sequencer model: issues instruction boundaries and keeps the live result
module seq_model (
   // clock
   input  wire logic        clk,
   // stall from priority control
   input  wire logic        hold_r,
   // boundary pulses and intermediate result
   output var  logic        instr_done,
   output var  logic        resume_req,
   output var  logic [15:0] acc_in
);
   // idle until the bench asks for a boundary
   initial begin
      instr_done = 1'b0;
      resume_req = 1'b0;
      acc_in     = 16'h0000;
   end
   // one boundary pulse, held off while stalled for up to 64 cycles; result held through the stall
   task automatic step(input bit resume, input logic [15:0] acc);
      int n;
      n = 0;
      @(negedge clk);
      while (hold_r !== 1'b0 && n < 64) begin // wait out a stall of up to 64 cycles
         @(negedge clk);
         n++;
      end
      acc_in     = acc;
      instr_done = !resume; // basic instruction end
      resume_req = resume;  // closing instruction of a priority program
      @(negedge clk);
      instr_done = 1'b0;
      resume_req = 1'b0;
   endtask : step
endmodule : seq_model
`default_nettype wire

/* File: verif/priority_interrupt_counter_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_counter_control_bench;
   import prio_ctl_pkg::*;
   localparam int TICK = 4000; // short tick so the timer case stays brief
   // stimulus and observed outputs
   logic        clk, rstn, key1, key2, mark, upl_p, upl_b, hand, dl_end;
   wire logic   instr_done, resume_req;
   wire logic [15:0] acc_in;
   logic        hold_r, acc_load_r, in_isr_r, parity_err_r;
   req_kind_t   req_kind_r;
   logic [11:0] req_addr_r, pc_r;
   logic [15:0] acc_out_r;
   // bookkeeping of the last boundary
   int          miscompares, compares, cnt_n, ord;
   req_kind_t   last_kind;
   logic [11:0] last_addr, cnt_addr;
   logic [15:0] acc_got;
   priority_interrupt_counter_control #(.TICK_CYCLES(TICK)) priority_interrupt_counter_control_i (
      .clk(clk), .rstn(rstn), .key_press_first(key1), .key_press_second(key2),
      .mark_discrete(mark), .uplink_pulse(upl_p), .uplink_bit(upl_b),
      .hand_out_of_detent(hand), .downlink_end(dl_end), .instr_done(instr_done),
      .resume_req(resume_req), .acc_in(acc_in), .hold_r(hold_r), .req_kind_r(req_kind_r),
      .req_addr_r(req_addr_r), .pc_r(pc_r), .acc_out_r(acc_out_r), .acc_load_r(acc_load_r),
      .in_isr_r(in_isr_r), .parity_err_r(parity_err_r));
   seq_model seq_model_i (.clk(clk), .hold_r(hold_r), .instr_done(instr_done),
      .resume_req(resume_req), .acc_in(acc_in));
   // clock
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // verdict
   task automatic test_done();
      if (miscompares == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // reset for 16 cycles
   task automatic do_reset();
      @(negedge clk);
      rstn = 1'b0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
   endtask : do_reset
   // one boundary, recording every request until the stall ends
   task automatic bound(input bit resume, input logic [15:0] acc);
      int n;
      last_kind = RK_NONE;
      last_addr = 12'h000;
      cnt_n     = 0;
      cnt_addr  = 12'h000;
      acc_got   = 16'h0000;
      seq_model_i.step(resume, acc);
      n = 0;
      while (hold_r !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      chk("hold", {31'h0, hold_r}, 32'h1);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (req_kind_r === RK_CNT) begin
            cnt_n++;
            cnt_addr = req_addr_r;
         end else if (req_kind_r !== RK_NONE) begin
            last_kind = req_kind_r;
            last_addr = req_addr_r;
            ord       = cnt_n;
         end
         if (acc_load_r === 1'b1) acc_got = acc_out_r;
         chk("parity_err", {31'h0, parity_err_r}, 32'h0);
      end while (hold_r !== 1'b0 && n < 64);
      chk("hold_drop", {31'h0, hold_r}, 32'h0);
   endtask : bound
   // one-cycle pulse on the downlink end line, off the sampling edge
   task automatic dl_pulse();
      @(negedge clk);
      dl_end = 1'b1; // telemetry timing unrelated to boundaries
      @(negedge clk);
      dl_end = 1'b0;
   endtask : dl_pulse
   // plain boundaries advance the program address
   task automatic t_plain();
      do_reset();
      chk("pc_reset", {20'h0, pc_r}, 32'h0);
      bound(0, 16'h0101);
      chk("kind", {30'h0, last_kind}, {30'h0, RK_NONE});
      chk("pc", {20'h0, pc_r}, 32'h1);
      bound(0, 16'h0102);
      chk("pc", {20'h0, pc_r}, 32'h2);
   endtask : t_plain
   // downlink entry, stay in program, restore
   task automatic t_downlink();
      do_reset();
      dl_pulse();
      bound(0, 16'h1111);
      chk("kind", {30'h0, last_kind}, {30'h0, RK_INT});
      chk("vector", {20'h0, pc_r}, 32'h81c);
      chk("in_isr", {31'h0, in_isr_r}, 32'h1);
      bound(0, 16'h1112);
      chk("pc", {20'h0, pc_r}, 32'h81d);
      bound(1, 16'h1113);
      chk("kind", {30'h0, last_kind}, {30'h0, RK_RES});
      chk("pc_back", {20'h0, pc_r}, 32'h1);
      chk("acc_back", {16'h0, acc_got}, 32'h1111);
      chk("in_isr", {31'h0, in_isr_r}, 32'h0);
   endtask : t_downlink
   // several sources at once, chained on resume in fixed order
   task automatic t_prio();
      do_reset();
      @(negedge clk);
      key1 = 1'b1;
      mark = 1'b1;
      hand = 1'b1;
      @(negedge clk);
      key1 = 1'b0;
      bound(0, 16'h2222);
      chk("vec_key1", {20'h0, pc_r}, 32'h810);
      bound(1, 16'h3333);
      chk("vec_mark", {20'h0, pc_r}, 32'h814);
      bound(1, 16'h3334);
      chk("vec_hand", {20'h0, pc_r}, 32'h820);
      dl_pulse();
      bound(0, 16'h3335);
      chk("no_nest", {30'h0, last_kind}, {30'h0, RK_NONE});
      chk("pc", {20'h0, pc_r}, 32'h821);
      bound(1, 16'h3336);
      chk("vec_down", {20'h0, pc_r}, 32'h81c);
      bound(1, 16'h3337);
      chk("kind", {30'h0, last_kind}, {30'h0, RK_RES});
      chk("pc_back", {20'h0, pc_r}, 32'h1);
      chk("acc_back", {16'h0, acc_got}, 32'h2222);
      mark = 1'b0;
      hand = 1'b0;
      @(negedge clk);
      key2 = 1'b1;
      @(negedge clk);
      key2 = 1'b0;
      bound(0, 16'h4444);
      chk("vec_key2", {20'h0, pc_r}, 32'h814);
   endtask : t_prio
   // fifteen serial bits, each a counter step, then the word interrupt
   task automatic t_uplink();
      do_reset();
      for (int i = 0; i < 15; i++) begin
         @(negedge clk);
         upl_p = 1'b1;
         upl_b = i[0];
         @(negedge clk);
         upl_p = 1'b0;
         bound(0, 16'h5555);
         chk("cnt_n", cnt_n, 32'h1);
         chk("cnt_addr", {20'h0, cnt_addr}, 32'h2);
         if (i < 14) chk("early", {30'h0, last_kind}, {30'h0, RK_NONE});
      end
      if (last_kind !== RK_INT) bound(0, 16'h5556);
      chk("vec_uplink", {20'h0, last_addr}, 32'h818);
   endtask : t_uplink
   // first main tick: time counter step before the timer interrupt
   task automatic t_timer();
      do_reset();
      repeat (TICK + 10) @(negedge clk);
      bound(0, 16'h6666);
      chk("cnt_n", cnt_n, 32'h1);
      chk("cnt_addr", {20'h0, cnt_addr}, 32'h0);
      chk("vec_t6", {20'h0, last_addr}, 32'h800);
      chk("cnt_first", ord, 32'h1);
   endtask : t_timer
   // main sequence
   initial begin
      {rstn, key1, key2, mark, upl_p, upl_b, hand, dl_end} = 8'h00;
      miscompares = 0;
      compares    = 0;
      ord         = 0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      t_plain();
      t_downlink();
      t_prio();
      t_uplink();
      t_timer();
      test_done();
   end
   // watchdog well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      test_done();
   end
endmodule : priority_interrupt_counter_control_bench
`default_nettype wire
